/* File: src/qct_regs.svh */
// register offsets, field positions, reset values and divider counts of the quad timer block
`ifndef QCT_REGS_SVH
`define QCT_REGS_SVH
`define QCT_AW 5
`define QCT_DW 8
`define QCT_A_CTRL 5'h00
`define QCT_A_MODE 5'h01
`define QCT_A_CLK 5'h02
`define QCT_A_T0L 5'h03
`define QCT_A_T0H 5'h04
`define QCT_A_T1L 5'h05
`define QCT_A_T1H 5'h06
`define QCT_A_T2CFG 5'h07
`define QCT_A_T2WIN 5'h08
`define QCT_A_T3CFG 5'h0c
`define QCT_A_T3WIN 5'h0d
`define QCT_A_STATUS 5'h11
`define QCT_A_MASK 5'h12
`define QCT_CTRL_RUN0 0
`define QCT_CTRL_RUN1 1
`define QCT_CTRL_FIRST_TIMER_GATE_BIT 2
`define QCT_CTRL_GATE1 3
`define QCT_CTRL_POL0 4
`define QCT_CTRL_POL1 5
`define QCT_MODE_M0 0
`define QCT_MODE_CT0 2
`define QCT_MODE_M1 4
`define QCT_MODE_CT1 6
`define QCT_CLK_PSC 0
`define QCT_CLK_T0SYS 2
`define QCT_CLK_T1SYS 3
`define QCT_TC_RUN 0
`define QCT_TC_SPLIT 1
`define QCT_TC_CAPT 2
`define QCT_TC_SRC 3
`define QCT_TC_CAPSRC 5
`define QCT_TC_LOSYS 6
`define QCT_TC_HISYS 7
`define QCT_ST_T0 0
`define QCT_ST_T0H 1
`define QCT_ST_T1 2
`define QCT_ST_T2L 3
`define QCT_ST_W 7
`define QCT_IN_EV0 0
`define QCT_IN_EV1 1
`define QCT_IN_GT0 2
`define QCT_IN_GT1 3
`define QCT_IN_RTC 4
`define QCT_IN_EXT 5
`define QCT_IN_CMP0 6
`define QCT_NIN 8
`define QCT_RST_BYTE 8'h00
`define QCT_DIV12_LAST 4'hb
`define QCT_DIV4_LAST 2'h3
`define QCT_DIV48_LAST 2'h3
`define QCT_OSC8_LAST 3'h7
`endif

/* File: src/qct_pkg.sv */
// types shared by the quad timer block
package qct_pkg;
  `include "qct_regs.svh"
  typedef enum logic [1:0] {qct_m13, qct_m16, qct_m8ar, qct_msplit} qct_mode_e;
  typedef enum logic [1:0] {qct_c_sys, qct_c_div12, qct_c_osc8, qct_c_cmp} qct_src_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } qct_sync_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rl;
    logic ovf_lo;
    logic ovf_hi;
  } qct_t23_s;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] mode;
    logic [3:0] clkcfg;
    logic [7:0] t0l;
    logic [7:0] t0h;
    logic [7:0] t1l;
    logic [7:0] t1h;
    logic [1:0][7:0] tcfg;
    logic [`QCT_ST_W-1:0] status;
    logic [`QCT_ST_W-1:0] mask;
    logic [3:0] div12;
    logic [1:0] div4;
    logic [1:0] div48;
    logic [1:0][2:0] osc8;
    logic [7:0] rdata;
    logic irq;
  } qct_top_s;
endpackage

/* File: src/qct_sync.sv */
// two-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module qct_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import qct_pkg::*;
  qct_sync_s st_q;
  qct_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = in_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges seen only on the settled stages
  assign level_o = st_q.s2;
  assign rise_o = st_q.s2 & ~st_q.s3;
  assign fall_o = ~st_q.s2 & st_q.s3;
endmodule

/* File: src/qct_t23.sv */
// one auto-reload timer with split and capture modes
`timescale 1ns/1ps
module qct_t23 (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic split_i,
  input wire logic capture_i,
  input wire logic en_lo_i,
  input wire logic en_hi_i,
  input wire logic cap_i,
  input wire logic wr_i,
  input wire logic [1:0] wsel_i,
  input wire logic [7:0] wdata_i,
  output logic [15:0] cnt_o,
  output logic [15:0] rl_o,
  output logic ovf_lo_o,
  output logic ovf_hi_o
);
  import qct_pkg::*;
  qct_t23_s st_q;
  qct_t23_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.ovf_lo = 1'b0;
    st_d.ovf_hi = 1'b0;
    if (capture_i) begin
      if (run_i && en_lo_i) begin
        st_d.cnt = st_q.cnt + 16'h1;
      end
      if (run_i && cap_i) begin
        st_d.rl = st_q.cnt;
        st_d.ovf_hi = 1'b1;
      end
    end else if (split_i) begin
      if (run_i && en_lo_i) begin
        st_d.ovf_lo = (st_q.cnt[7:0] == 8'hff);
        st_d.cnt[7:0] = st_d.ovf_lo ? st_q.rl[7:0] : st_q.cnt[7:0] + 8'h1;
      end
      if (run_i && en_hi_i) begin
        st_d.ovf_hi = (st_q.cnt[15:8] == 8'hff);
        st_d.cnt[15:8] = st_d.ovf_hi ? st_q.rl[15:8] : st_q.cnt[15:8] + 8'h1;
      end
    end else if (run_i && en_lo_i) begin
      st_d.ovf_lo = (st_q.cnt[7:0] == 8'hff);
      st_d.ovf_hi = (st_q.cnt == 16'hffff);
      st_d.cnt = st_d.ovf_hi ? st_q.rl : st_q.cnt + 16'h1;
    end
    if (wr_i) begin
      case (wsel_i)
        2'h0: st_d.rl[7:0] = wdata_i;
        2'h1: st_d.rl[15:8] = wdata_i;
        2'h2: st_d.cnt[7:0] = wdata_i;
        default: st_d.cnt[15:8] = wdata_i;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cnt_o = st_q.cnt;
  assign rl_o = st_q.rl;
  assign ovf_lo_o = st_q.ovf_lo;
  assign ovf_hi_o = st_q.ovf_hi;
endmodule

/* File: src/qct_top.sv */
// quad counter/timer block with register port and interrupt
`timescale 1ns/1ps
`include "qct_regs.svh"

module qct_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic first_event_input_pin_i,
  input wire logic second_event_input_pin_i,
  input wire logic first_gate_input_i,
  input wire logic second_gate_input_i,
  input wire logic rtc_osc_i,
  input wire logic ext_osc_i,
  input wire logic first_comparator_output_i,
  input wire logic second_comparator_output_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  import qct_pkg::*;

  qct_top_s st_q;
  qct_top_s st_d;

  logic [`QCT_NIN-1:0] pins;
  logic [`QCT_NIN-1:0] sy_lvl;
  logic [`QCT_NIN-1:0] sy_rise;
  logic [`QCT_NIN-1:0] sy_fall;

  logic tick12;
  logic tick4;
  logic tick48;
  logic [1:0] osc8_tick;
  logic psc_tick;
  logic tclk0;
  logic tclk1;
  logic en0;
  logic en1;
  logic en0h;
  logic ovf0;
  logic ovf0h;
  logic ovf1;
  logic [16:0] nx0;
  logic [16:0] nx1;
  qct_mode_e mode0;
  qct_mode_e mode1;
  logic [`QCT_ST_W-1:0] events;
  logic st_hit;

  logic [1:0] u_wr;
  logic [1:0][1:0] u_sel;
  logic [1:0] u_en_lo;
  logic [1:0] u_en_hi;
  logic [1:0] u_cap;
  logic [1:0] u_src_tick;
  logic [1:0][15:0] u_cnt;
  logic [1:0][15:0] u_rl;
  logic [1:0] u_ovf_lo;
  logic [1:0] u_ovf_hi;

  // gate enable table of the classic timers
  function automatic logic run_ok(input logic run, input logic gate, input logic gin, input logic pol);
    run_ok = run && (!gate || (gin == pol));
  endfunction

  // one count step of a classic timer, overflow in the top bit
  function automatic logic [16:0] t01_step(input logic [15:0] v, input qct_mode_e m);
    logic [12:0] n13;
    logic [16:0] r;
    n13 = {v[15:8], v[4:0]} + 13'h1;
    r = {1'b0, v};
    case (m)
      qct_m13: begin
        r = {(n13 == 13'h0), n13[12:5], v[7:5], n13[4:0]};
      end
      qct_m16: begin
        r = {(v == 16'hffff), v + 16'h1};
      end
      qct_m8ar: begin
        if (v[7:0] == 8'hff) begin
          r = {1'b1, v[15:8], v[15:8]};
        end else begin
          r = {1'b0, v[15:8], v[7:0] + 8'h1};
        end
      end
      default: begin
        r = {(v[7:0] == 8'hff), v[15:8], v[7:0] + 8'h1};
      end
    endcase
    return r;
  endfunction

  // hit and byte select of a four-byte timer window
  function automatic logic [2:0] win_dec(input logic [4:0] a, input logic [4:0] base);
    logic [4:0] off;
    off = a - base;
    win_dec = {(a >= base) && (off < 5'h4), off[1:0]};
  endfunction

  assign pins[`QCT_IN_EV0] = first_event_input_pin_i;
  assign pins[`QCT_IN_EV1] = second_event_input_pin_i;
  assign pins[`QCT_IN_GT0] = first_gate_input_i;
  assign pins[`QCT_IN_GT1] = second_gate_input_i;
  assign pins[`QCT_IN_RTC] = rtc_osc_i;
  assign pins[`QCT_IN_EXT] = ext_osc_i;
  assign pins[`QCT_IN_CMP0] = first_comparator_output_i;
  assign pins[`QCT_IN_CMP0+1] = second_comparator_output_i;

  genvar gi;
  generate
    for (gi = 0; gi < `QCT_NIN; gi = gi + 1) begin : g_sync
      qct_sync u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_i(pins[gi]),
        .level_o(sy_lvl[gi]),
        .rise_o(sy_rise[gi]),
        .fall_o(sy_fall[gi])
      );
    end

    for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
      logic [2:0] dec;
      logic [7:0] cfg;
      assign cfg = st_q.tcfg[gi];
      assign dec = win_dec(addr_i, (gi == 0) ? `QCT_A_T2WIN : `QCT_A_T3WIN);
      assign u_wr[gi] = wr_i && dec[2];
      assign u_sel[gi] = dec[1:0];
      // osc over eight for timer 2 is rtc, for timer 3 external
      always_comb begin
        case (qct_src_e'(cfg[`QCT_TC_SRC +: 2]))
          qct_c_sys: u_src_tick[gi] = 1'b1;
          qct_c_div12: u_src_tick[gi] = tick12;
          qct_c_osc8: u_src_tick[gi] = osc8_tick[gi];
          default: u_src_tick[gi] = sy_rise[`QCT_IN_CMP0 + gi];
        endcase
      end
      assign u_en_lo[gi] = cfg[`QCT_TC_LOSYS] | u_src_tick[gi];
      assign u_en_hi[gi] = cfg[`QCT_TC_HISYS] | u_src_tick[gi];
      assign u_cap[gi] = cfg[`QCT_TC_CAPSRC] ? sy_rise[`QCT_IN_CMP0 + gi] : sy_rise[`QCT_IN_RTC + gi];
      qct_t23 u_t23 (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .run_i(cfg[`QCT_TC_RUN]),
        .split_i(cfg[`QCT_TC_SPLIT]),
        .capture_i(cfg[`QCT_TC_CAPT]),
        .en_lo_i(u_en_lo[gi]),
        .en_hi_i(u_en_hi[gi]),
        .cap_i(u_cap[gi]),
        .wr_i(u_wr[gi]),
        .wsel_i(u_sel[gi]),
        .wdata_i(wdata_i),
        .cnt_o(u_cnt[gi]),
        .rl_o(u_rl[gi]),
        .ovf_lo_o(u_ovf_lo[gi]),
        .ovf_hi_o(u_ovf_hi[gi])
      );
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    // shared dividers as one-cycle enables
    tick12 = (st_q.div12 == `QCT_DIV12_LAST);
    tick4 = (st_q.div4 == `QCT_DIV4_LAST);
    tick48 = tick12 && (st_q.div48 == `QCT_DIV48_LAST);
    osc8_tick[0] = sy_rise[`QCT_IN_RTC] && (st_q.osc8[0] == `QCT_OSC8_LAST);
    osc8_tick[1] = sy_rise[`QCT_IN_EXT] && (st_q.osc8[1] == `QCT_OSC8_LAST);
    st_d.div12 = tick12 ? 4'h0 : st_q.div12 + 4'h1;
    st_d.div4 = st_q.div4 + 2'h1;
    if (tick12) begin
      st_d.div48 = st_q.div48 + 2'h1;
    end
    if (sy_rise[`QCT_IN_RTC]) begin
      st_d.osc8[0] = st_q.osc8[0] + 3'h1;
    end
    if (sy_rise[`QCT_IN_EXT]) begin
      st_d.osc8[1] = st_q.osc8[1] + 3'h1;
    end

    case (st_q.clkcfg[`QCT_CLK_PSC +: 2])
      2'h0: psc_tick = tick12;
      2'h1: psc_tick = tick4;
      2'h2: psc_tick = tick48;
      default: psc_tick = osc8_tick[1];
    endcase

    mode0 = qct_mode_e'(st_q.mode[`QCT_MODE_M0 +: 2]);
    mode1 = qct_mode_e'(st_q.mode[`QCT_MODE_M1 +: 2]);
    tclk0 = st_q.clkcfg[`QCT_CLK_T0SYS] | psc_tick;
    tclk1 = st_q.clkcfg[`QCT_CLK_T1SYS] | psc_tick;

    // timer 0
    en0 = run_ok(st_q.ctrl[`QCT_CTRL_RUN0], st_q.ctrl[`QCT_CTRL_FIRST_TIMER_GATE_BIT],
                 sy_lvl[`QCT_IN_GT0], st_q.ctrl[`QCT_CTRL_POL0]) &&
          (st_q.mode[`QCT_MODE_CT0] ? sy_fall[`QCT_IN_EV0] : tclk0);
    nx0 = t01_step({st_q.t0h, st_q.t0l}, mode0);
    ovf0 = en0 && nx0[16];
    if (en0) begin
      st_d.t0h = nx0[15:8];
      st_d.t0l = nx0[7:0];
    end
    // split mode: high byte is a timer run by the second run bit
    en0h = (mode0 == qct_msplit) && st_q.ctrl[`QCT_CTRL_RUN1] && tclk0;
    ovf0h = en0h && (st_q.t0h == 8'hff);
    if (en0h) begin
      st_d.t0h = st_q.t0h + 8'h1;
    end

    // timer 1, held while in split mode
    en1 = (mode1 != qct_msplit) &&
          run_ok(st_q.ctrl[`QCT_CTRL_RUN1], st_q.ctrl[`QCT_CTRL_GATE1],
                 sy_lvl[`QCT_IN_GT1], st_q.ctrl[`QCT_CTRL_POL1]) &&
          (st_q.mode[`QCT_MODE_CT1] ? sy_fall[`QCT_IN_EV1] : tclk1);
    nx1 = t01_step({st_q.t1h, st_q.t1l}, mode1);
    ovf1 = en1 && nx1[16];
    if (en1) begin
      st_d.t1h = nx1[15:8];
      st_d.t1l = nx1[7:0];
    end

    // register writes take priority over counting
    if (wr_i) begin
      if (addr_i == `QCT_A_CTRL) begin
        st_d.ctrl = wdata_i[5:0];
      end else if (addr_i == `QCT_A_MODE) begin
        st_d.mode = wdata_i;
      end else if (addr_i == `QCT_A_CLK) begin
        st_d.clkcfg = wdata_i[3:0];
      end else if (addr_i == `QCT_A_T0L) begin
        st_d.t0l = wdata_i;
      end else if (addr_i == `QCT_A_T0H) begin
        st_d.t0h = wdata_i;
      end else if (addr_i == `QCT_A_T1L) begin
        st_d.t1l = wdata_i;
      end else if (addr_i == `QCT_A_T1H) begin
        st_d.t1h = wdata_i;
      end else if (addr_i == `QCT_A_T2CFG) begin
        st_d.tcfg[0] = wdata_i;
      end else if (addr_i == `QCT_A_T3CFG) begin
        st_d.tcfg[1] = wdata_i;
      end else if (addr_i == `QCT_A_MASK) begin
        st_d.mask = wdata_i[`QCT_ST_W-1:0];
      end
    end

    // read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == `QCT_A_CTRL) begin
        st_d.rdata = {2'h0, st_q.ctrl};
      end else if (addr_i == `QCT_A_MODE) begin
        st_d.rdata = st_q.mode;
      end else if (addr_i == `QCT_A_CLK) begin
        st_d.rdata = {4'h0, st_q.clkcfg};
      end else if (addr_i == `QCT_A_T0L) begin
        st_d.rdata = st_q.t0l;
      end else if (addr_i == `QCT_A_T0H) begin
        st_d.rdata = st_q.t0h;
      end else if (addr_i == `QCT_A_T1L) begin
        st_d.rdata = st_q.t1l;
      end else if (addr_i == `QCT_A_T1H) begin
        st_d.rdata = st_q.t1h;
      end else if (addr_i == `QCT_A_T2CFG) begin
        st_d.rdata = st_q.tcfg[0];
      end else if (win_dec(addr_i, `QCT_A_T2WIN) >= 3'h4) begin
        st_d.rdata = pick(u_sel[0], u_rl[0], u_cnt[0]);
      end else if (addr_i == `QCT_A_T3CFG) begin
        st_d.rdata = st_q.tcfg[1];
      end else if (win_dec(addr_i, `QCT_A_T3WIN) >= 3'h4) begin
        st_d.rdata = pick(u_sel[1], u_rl[1], u_cnt[1]);
      end else if (addr_i == `QCT_A_STATUS) begin
        st_d.rdata = {1'b0, st_q.status};
      end else if (addr_i == `QCT_A_MASK) begin
        st_d.rdata = {1'b0, st_q.mask};
      end
    end

    // sticky status, cleared by read, a new event wins
    events = '0;
    events[`QCT_ST_T0] = ovf0;
    events[`QCT_ST_T0H] = ovf0h;
    events[`QCT_ST_T1] = ovf1;
    events[`QCT_ST_T2L] = u_ovf_lo[0];
    events[`QCT_ST_T2L+1] = u_ovf_hi[0];
    events[`QCT_ST_T2L+2] = u_ovf_lo[1];
    events[`QCT_ST_T2L+3] = u_ovf_hi[1];
    st_hit = rd_i && (addr_i == `QCT_A_STATUS);
    st_d.status = (st_hit ? '0 : st_q.status) | events;
    st_d.irq = |(st_d.status & st_d.mask);
  end

  // byte of a reload/count window
  function automatic logic [7:0] pick(input logic [1:0] sel, input logic [15:0] rl, input logic [15:0] cnt);
    case (sel)
      2'h0: pick = rl[7:0];
      2'h1: pick = rl[15:8];
      2'h2: pick = cnt[7:0];
      default: pick = cnt[15:8];
    endcase
  endfunction

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign irq_o = st_q.irq;
endmodule

/* File: src/qct_dummy_unused.sv */
// no logic here: the timer block lives in its top, synchroniser and reload-timer files

/* File: tb/qct_top_sva.sv */
// assertion checker for the quad timer block ports
`timescale 1ns/1ps
`include "qct_regs.svh"
module qct_top_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o
);
  logic [6:0] mask_q;
  logic [5:0] ctrl_q;
  logic [7:0] mode_q;
  logic [3:0] clk_q;
  logic [7:0] t0h_q;
  logic hold_q;
  // shadows of written registers; hold_q: timer 0 idle since its high byte was written
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= 7'h00;
      ctrl_q <= 6'h00;
      mode_q <= 8'h00;
      clk_q <= 4'h0;
      t0h_q <= 8'h00;
      hold_q <= 1'b1;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `QCT_A_MASK: mask_q <= wdata_i[6:0];
          `QCT_A_CTRL: ctrl_q <= wdata_i[5:0];
          `QCT_A_MODE: mode_q <= wdata_i;
          `QCT_A_CLK: clk_q <= wdata_i[3:0];
          `QCT_A_T0H: t0h_q <= wdata_i;
          default: ;
        endcase
      end
      hold_q <= (ctrl_q[1:0] == 2'b00) && (hold_q || (wr_i && addr_i == `QCT_A_T0H));
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside the read slot");
  a_unmapped_zero: assert property (rd_i && addr_i > `QCT_A_MASK |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_mask_back: assert property (rd_i && addr_i == `QCT_A_MASK |=> rdata_o[6:0] == $past(mask_q))
    else $error("mask readback wrong");
  a_ctrl_back: assert property (rd_i && addr_i == `QCT_A_CTRL |=> rdata_o[5:0] == $past(ctrl_q))
    else $error("control readback wrong");
  a_mode_back: assert property (rd_i && addr_i == `QCT_A_MODE |=> (rdata_o & 8'h77) == ($past(mode_q) & 8'h77))
    else $error("mode readback wrong");
  a_clk_back: assert property (rd_i && addr_i == `QCT_A_CLK |=> rdata_o[3:0] == $past(clk_q))
    else $error("clock select readback wrong");
  a_stopped_holds: assert property (rd_i && addr_i == `QCT_A_T0H && hold_q |=> rdata_o == $past(t0h_q))
    else $error("stopped timer high byte moved");
  a_irq_masked: assert property (mask_q == 7'h00 [*2] |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_irq_cause: assert property ($rose(irq_o) |-> (mask_q | $past(mask_q)) != 7'h00)
    else $error("interrupt rose without enabled source");
  c_irq_up: cover property ($rose(irq_o));
  c_status_hit: cover property (rd_i && addr_i == `QCT_A_STATUS ##1 rdata_o != 8'h00);
  c_gap_read: cover property (rd_i && addr_i > `QCT_A_MASK);
endmodule
bind qct_top qct_top_sva u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

/* File: tb/qct_far.sv */
// far-side model: event pins, gate inputs, oscillators and comparators
`timescale 1ns/1ps
module qct_far (
  input wire logic clock_i,
  output logic [7:0] pins_o
);
  initial pins_o = 8'h03;
  // n edge pairs, every level held for hold clocks
  task automatic pulse(input int idx, input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clock_i);
      pins_o[idx] <= ~pins_o[idx];
      repeat (hold - 1) @(posedge clock_i);
    end
  endtask
  task automatic set_pin(input int idx, input logic v);
    @(posedge clock_i);
    pins_o[idx] <= v;
  endtask
endmodule

/* File: tb/quad_counter_timer_block_bench.sv */
// self-checking bench for the quad timer block
`timescale 1ns/1ps
`include "qct_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module quad_counter_timer_block_bench;
  import qct_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] pins, rdata_o, rv;
  logic irq_o;
  logic [31:0] seed = 32'hb624;
  int miscompares = 0;
  int checked = 0;
  int dv[4] = '{12, 4, 48, 48};
  logic [4:0] ra[7] = '{5'h00, 5'h01, 5'h02, 5'h12, 5'h03, 5'h04, 5'h1f};
  logic [7:0] rm[7] = '{8'h3c, 8'h77, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'h00};
  logic [7:0] xq[$];
  always #20 clock_i = ~clock_i;
  qct_far far (.clock_i(clock_i), .pins_o(pins));
  qct_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .first_event_input_pin_i(pins[0]), .second_event_input_pin_i(pins[1]),
    .first_gate_input_i(pins[2]), .second_gate_input_i(pins[3]), .rtc_osc_i(pins[4]), .ext_osc_i(pins[5]),
    .first_comparator_output_i(pins[6]), .second_comparator_output_i(pins[7]), .rdata_o(rdata_o), .irq_o(irq_o));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // expected {high, low} of timer 0 after n counts
  function automatic logic [15:0] model(input int m, input logic [7:0] l, input logic [7:0] h, input int n,
    output bit ov);
    logic [16:0] c;
    ov = 0;
    for (int i = 0; i < n; i++) begin
      if (m == 0) begin
        c = {h, l[4:0]} + 1;
        ov |= c[13];
        {h, l[4:0]} = c[12:0];
      end else if (m == 1) begin
        c = {h, l} + 1;
        ov |= c[16];
        {h, l} = c[15:0];
      end else begin
        ov |= (l == 8'hff);
        l = (l == 8'hff) ? h : l + 8'h01;
      end
    end
    return {h, l};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic ev(input int m, input logic [7:0] l, input logic [7:0] h, input int n, input int k,
    input logic [7:0] c, input logic [7:0] mk);
    logic [15:0] e;
    bit ov;
    e = model(m, l, h, k, ov);
    wr(`QCT_A_MASK, mk);
    wr(`QCT_A_MODE, 8'(m) | 8'h04);
    wr(`QCT_A_T0L, l);
    wr(`QCT_A_T0H, h);
    rd(`QCT_A_STATUS);
    wr(`QCT_A_CTRL, c);
    far.pulse(`QCT_IN_EV0, n, 2);
    repeat (6) @(posedge clock_i);
    wr(`QCT_A_CTRL, 8'h00);
    rd(`QCT_A_T0L);
    `CHK(rv, e[7:0])
    rd(`QCT_A_T0H);
    `CHK(rv, e[15:8])
    `CHK(irq_o, ov & mk[0])
    rd(`QCT_A_STATUS);
    `CHK(rv[0], ov)
    repeat (2) @(posedge clock_i);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic tmr(input logic [7:0] ck, input int n, input int e);
    logic [15:0] c;
    wr(`QCT_A_MODE, 8'h01);
    wr(`QCT_A_CLK, ck);
    wr(`QCT_A_T0L, 8'h00);
    wr(`QCT_A_T0H, 8'h00);
    wr(`QCT_A_CTRL, 8'h01);
    repeat (n) @(posedge clock_i);
    wr(`QCT_A_CTRL, 8'h00);
    rd(`QCT_A_T0L);
    c[7:0] = rv;
    rd(`QCT_A_T0H);
    c[15:8] = rv;
    `CHK(c >= 16'(e - 1) && c <= 16'(e + 1), 1'b1)
  endtask
  // twenty ticks from 0xfff0 with reload 0xfff0 end at 0xfff4
  task automatic t23(input logic [4:0] b, input logic [7:0] cfg, input int n, input int pin, input int s);
    for (int i = 1; i < 5; i++) begin
      wr(b + 5'(i), (i == 2 || i == 4) ? 8'hff : 8'hf0);
    end
    rd(`QCT_A_STATUS);
    wr(b, cfg);
    if (pin < 0) begin
      repeat (n) @(posedge clock_i);
    end else begin
      far.pulse(pin, n, 2);
      repeat (6) @(posedge clock_i);
    end
    wr(b, 8'h00);
    rd(b + 5'h3);
    `CHK(rv >= 8'hf3 && rv <= 8'hf5, 1'b1)
    rd(`QCT_A_STATUS);
    `CHK(rv[s] | rv[s + 1], 1'b1)
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #800000;
    miscompares++;
    close_out();
  end
  initial begin
    int n;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      rd(5'(a));
      `CHK(rv, 8'h00)
    end
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      wdata_i <= 8'h00;
      rv = rnd() & rm[i];
      xq.push_back(rv);
      wr(ra[i], rv | ~rm[i] & 8'h80 & rm[i]);
    end
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      `CHK(rv & rm[i], xq.pop_front())
    end
    $display("test register access done");
    n = (rnd() & 8'h07) + 1;
    ev(1, 8'hfd, 8'hff, n, n, 8'h01, 8'h7f);
    ev(0, 8'hfe, 8'hff, 2, 2, 8'h01, 8'h7f);
    ev(2, 8'hfe, 8'h80, 3, 3, 8'h01, 8'h00);
    far.set_pin(`QCT_IN_GT0, 1'b0);
    ev(1, 8'h10, 8'h00, 4, 0, 8'h15, 8'h7f);
    far.set_pin(`QCT_IN_GT0, 1'b1);
    ev(1, 8'h10, 8'h00, 4, 4, 8'h15, 8'h7f);
    $display("test event counting done");
    wr(`QCT_A_MODE, 8'h30);
    wr(`QCT_A_CLK, 8'h08);
    wr(`QCT_A_T1L, 8'h55);
    wr(`QCT_A_CTRL, 8'h02);
    repeat (20) @(posedge clock_i);
    wr(`QCT_A_CTRL, 8'h00);
    rd(`QCT_A_T1L);
    `CHK(rv, 8'h55)
    // timer 0 split: both bytes on system clock, twenty counts each
    wr(`QCT_A_MODE, 8'h03);
    wr(`QCT_A_CLK, 8'h04);
    wr(`QCT_A_T0L, 8'hf0);
    wr(`QCT_A_T0H, 8'hf8);
    rd(`QCT_A_STATUS);
    wr(`QCT_A_CTRL, 8'h03);
    repeat (18) @(posedge clock_i);
    wr(`QCT_A_CTRL, 8'h00);
    rd(`QCT_A_T0L);
    `CHK(rv, 8'h04)
    rd(`QCT_A_T0H);
    `CHK(rv, 8'h0c)
    rd(`QCT_A_STATUS);
    `CHK(rv[1:0], 2'b11)
    // timer 1 counts its own pin, gated by a low-active gate input
    wr(`QCT_A_MODE, 8'h50);
    wr(`QCT_A_T1L, 8'hfe);
    wr(`QCT_A_T1H, 8'hff);
    wr(`QCT_A_CTRL, 8'h0a);
    far.pulse(`QCT_IN_EV1, 3, 2);
    repeat (6) @(posedge clock_i);
    wr(`QCT_A_CTRL, 8'h00);
    rd(`QCT_A_T1L);
    `CHK(rv, 8'h01)
    rd(`QCT_A_T1H);
    `CHK(rv, 8'h00)
    rd(`QCT_A_STATUS);
    `CHK(rv[2], 1'b1)
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        fork
          far.pulse(`QCT_IN_EXT, 90, 3);
        join_none
      end
      tmr(8'(k), 478, 480 / dv[k]);
    end
    tmr(8'h04, 478, 480);
    $display("test timer clocks done");
    t23(`QCT_A_T2CFG, 8'h01, 18, -1, 3);
    t23(`QCT_A_T2CFG, 8'h03, 18, -1, 3);
    t23(`QCT_A_T3CFG, 8'h09, 238, -1, 5);
    t23(`QCT_A_T2CFG, 8'h11, 160, `QCT_IN_RTC, 3);
    t23(`QCT_A_T2CFG, 8'h19, 20, `QCT_IN_CMP0, 3);
    t23(`QCT_A_T3CFG, 8'h11, 160, `QCT_IN_EXT, 5);
    t23(`QCT_A_T3CFG, 8'h19, 20, 7, 5);
    rd(`QCT_A_STATUS);
    wr(`QCT_A_T2CFG, 8'h25);
    far.pulse(`QCT_IN_CMP0, 1, 2);
    repeat (6) @(posedge clock_i);
    rd(`QCT_A_STATUS);
    `CHK(rv[4], 1'b1)
    wr(`QCT_A_T2CFG, 8'h00);
    $display("test reload timers done");
    close_out();
  end
endmodule
